//--- core/spa_params.svh
// constants of the serial port core: addresses, field positions, resets
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH

// bank and port addresses
`define SPA_BANK_LO 3'h5
`define SPA_BANK_HI 3'h7
`define SPA_PORT_CTRL 3'h0
`define SPA_PORT_TX 3'h3
`define SPA_PORT_RX 3'h4
`define SPA_PORT_BAUD 3'h5

// serial control fields
`define SPA_B_SYNC 0
`define SPA_B_LEN 1
`define SPA_B_PARITY_ERROR_FLAG 3
`define SPA_B_FRAMING_ERROR_FLAG 4
`define SPA_B_BBF 5
`define SPA_B_PEN 8
`define SPA_B_PODD 9
`define SPA_B_CREN 11
`define SPA_B_SREN 12
`define SPA_B_CLOCK_SOURCE_SELECT 13
`define SPA_B_CODEC 14
`define SPA_B_TBE 15
`define SPA_CTRL_WMASK 16'h7B07
`define SPA_CTRL_RST 16'h0805
`define SPA_BAUD_RST 16'h0000

// timing counts in oversampling pulses and clock cycles
`define SPA_PRESCALE_LAST 2'h3
`define SPA_BIT_LAST 4'hF
`define SPA_VOTE_A 4'h6
`define SPA_VOTE_B 4'h7
`define SPA_VOTE_C 4'h8
`define SPA_MID 4'h7
`define SPA_SYNC_HALF 4'h7
`define SPA_MIN_LAST 4'h5

`endif

//--- core/spa_pkg.sv
// types of the serial port core
package spa_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP = 3'h6
  } spa_tx_state_type;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP = 3'h6
  } spa_rx_state_type;
endpackage

//--- core/spa_baud_gen.sv
// processor clock output divider and oversampling pulse generator
`timescale 1ns/1ps
`include "spa_params.svh"

module spa_baud_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // divisor from software
  input wire logic [15:0] divisor,
  // outputs
  output logic cpuClockOut,
  output logic tick
);
  logic [1:0] prescale_r;
  logic [15:0] count_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prescale_r <= 2'h0;
      cpuClockOut <= 1'b0;
    end else begin
      prescale_r <= prescale_r + 2'h1;
      cpuClockOut <= prescale_r[1];
    end
  end

  // a new divisor takes effect at the next reload, never mid count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_r <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (prescale_r == `SPA_PRESCALE_LAST) begin
        if (count_r == 16'h0000) begin
          tick <= 1'b1;
          count_r <= divisor;
        end else begin
          count_r <= count_r - 16'h0001;
        end
      end
    end
  end
endmodule

//--- core/spa_core.sv
// serial port core: baud generation, async and sync transfer, port registers
`timescale 1ns/1ps
`include "spa_params.svh"

// How it works
// - bit rate is processor clock over sixteen times divisor plus one
// - divisor zero gives processor clock over sixteen
// - divisor takes any sixteen-bit value up to all ones
// - control bits 0 and 14 clear select full-duplex asynchronous mode
// - frame: start, six to nine data bits, optional parity, stop
// - nine-bit transmit shift and holding; only holding is writable
// - transmit pin idles high whenever async transmission is idle
// - write goes straight to empty shift register, else waits; flag clears
// - write with both transmit registers full is dropped
// - start bit, data least significant first, parity, then stop
// - transmit interrupt once last data or parity bit has left
// - start bit voted on oversampling pulses seven, eight, nine
// - vote of one rejects start and keeps hunting; zero loads data
// - parity mismatch sets bit 3, cleared by software only
// - parity error travels with its word through both buffers
// - missing stop bit sets bit 4, receiver hunts again
// - frame end moves word to holding, raises interrupt, rearms edge
// - holding full at frame end sets both-full and blocks reception
// - holding read clears both-full and moves pending word up
// - transmit shift at bank 7 port 3, holding at bank 5 port 3
// - receive shift at bank 7 port 4, holding at bank 5 port 4
// - bit 0 set, bit 14 clear: half-duplex sync, bit 13 picks clocking
// - sync data on data pin, clock on clock pin, rate kept low
// - bit 15 reads one when transmit holding is empty, one at reset
// - bit 13 set takes clock from pin as slave; clear drives it
module spa_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // port register access
  input wire logic [2:0] bank,
  input wire logic [2:0] portSel,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData_r,
  // events to the processor
  output logic txDoneIrq_r,
  output logic rxDoneIrq_r,
  // transmit / clock pin
  input wire logic txClkIn,
  output logic txClkOut_r,
  output logic txClkOe_r,
  // receive / data pin
  input wire logic rxDataIn,
  output logic rxDataOut_r,
  output logic rxDataOe_r,
  // processor clock output
  output logic cpuClockOut
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl_r;
  logic [15:0] baudDivisor_r;
  logic parity_error_flag_r, framing_error_flag_r, bbf_r;
  logic [8:0] txShift_r, txHold_r, rxShift_r, rxHold_r;
  logic txShiftFull_r, txHoldFull_r, rxHoldFull_r;
  spa_pkg::spa_tx_state_type txState_r;
  spa_pkg::spa_rx_state_type rxState_r;
  logic [3:0] txCnt_r, txIdx_r, rxCnt_r, rxIdx_r, syncDiv_r;
  logic [1:0] vote_r;
  logic rxPerrPend_r, rxDone_r, ferrSet_r;
  logic rxMeta_r, rxSync_r, rxPrev_r, clkMeta_r, clkSync_r, clkPrev_r;
  logic syncClk_r;
  logic tick;

  spa_baud_gen baudGen (
    .ref_clk(ref_clk),
    .rst(rst),
    .divisor(baudDivisor_r),
    .cpuClockOut(cpuClockOut),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode and mode
  logic selLo, selHi, wrCtrl, wrBaud, wrTxHold, rdRxHold;
  logic asyncMode, syncMode, master, syncRxEn;
  logic [3:0] lastIdx;
  logic [8:0] dataMask;
  logic txParity, rxParity;

  assign selLo = (bank == `SPA_BANK_LO);
  assign selHi = (bank == `SPA_BANK_HI);
  assign wrCtrl = wrEn && selLo && (portSel == `SPA_PORT_CTRL);
  assign wrBaud = wrEn && selLo && (portSel == `SPA_PORT_BAUD);
  assign wrTxHold = wrEn && selLo && (portSel == `SPA_PORT_TX);
  assign rdRxHold = rdEn && selLo && (portSel == `SPA_PORT_RX);
  assign asyncMode = !ctrl_r[`SPA_B_SYNC] && !ctrl_r[`SPA_B_CODEC];
  assign syncMode = ctrl_r[`SPA_B_SYNC] && !ctrl_r[`SPA_B_CODEC];
  assign master = !ctrl_r[`SPA_B_CLOCK_SOURCE_SELECT];
  // single reception only counts as master
  assign syncRxEn = syncMode && (ctrl_r[`SPA_B_CREN] ||
                    (master && ctrl_r[`SPA_B_SREN]));
  assign lastIdx = `SPA_MIN_LAST + {2'b00, ctrl_r[`SPA_B_LEN +: 2]};
  assign dataMask = 9'h1FF >> (4'h8 - lastIdx);
  assign txParity = ^(txShift_r & dataMask) ^ ctrl_r[`SPA_B_PODD];
  assign rxParity = ^(rxShift_r & dataMask) ^ ctrl_r[`SPA_B_PODD];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and sync clock edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
      clkMeta_r <= 1'b1;
      clkSync_r <= 1'b1;
      clkPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= rxDataIn;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
      clkMeta_r <= txClkIn;
      clkSync_r <= clkMeta_r;
      clkPrev_r <= clkSync_r;
    end
  end

  logic txActive, syncToggle, syncRise, syncFall;
  assign txActive = (txState_r != spa_pkg::TX_IDLE) || txShiftFull_r;
  // half period of eight pulses keeps the master clock far below 6.4 MHz
  assign syncToggle = tick && (syncDiv_r == `SPA_SYNC_HALF);
  assign syncRise = master ? (syncToggle && !syncClk_r)
                           : (clkSync_r && !clkPrev_r);
  assign syncFall = master ? (syncToggle && syncClk_r)
                           : (!clkSync_r && clkPrev_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncClk_r <= 1'b1;
      syncDiv_r <= 4'h0;
    end else if (syncMode && master && (txActive || syncRxEn)) begin
      if (tick) begin
        syncDiv_r <= (syncDiv_r == `SPA_SYNC_HALF) ? 4'h0 : syncDiv_r + 4'h1;
      end
      if (syncToggle) begin
        syncClk_r <= !syncClk_r;
      end
    end else begin
      syncClk_r <= 1'b1;
      syncDiv_r <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, divisor and status flags
  logic rxMove;
  assign rxMove = (rxDone_r && !(rxHoldFull_r && !rdRxHold)) ||
                  (!rxDone_r && rdRxHold && bbf_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `SPA_CTRL_RST;
      baudDivisor_r <= `SPA_BAUD_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= wrData & `SPA_CTRL_WMASK;
      end else if (rxDone_r && syncMode && master && !ctrl_r[`SPA_B_CREN]) begin
        ctrl_r[`SPA_B_SREN] <= 1'b0;
      end
      if (wrBaud) begin
        baudDivisor_r <= wrData;
      end
    end
  end

  // a flag being set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parity_error_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
    end else begin
      parity_error_flag_r <= (rxMove && rxPerrPend_r) ||
                (parity_error_flag_r && !(wrCtrl && !wrData[`SPA_B_PARITY_ERROR_FLAG]));
      framing_error_flag_r <= ferrSet_r ||
                (framing_error_flag_r && !(wrCtrl && !wrData[`SPA_B_FRAMING_ERROR_FLAG]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  logic [15:0] status;
  always_comb begin
    status = ctrl_r;
    status[`SPA_B_PARITY_ERROR_FLAG] = parity_error_flag_r;
    status[`SPA_B_FRAMING_ERROR_FLAG] = framing_error_flag_r;
    status[`SPA_B_BBF] = bbf_r;
    status[`SPA_B_TBE] = !txHoldFull_r;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 16'h0000;
    end else if (rdEn) begin
      rdData_r <= 16'h0000;
      if (selLo && portSel == `SPA_PORT_CTRL) begin
        rdData_r <= status;
      end else if (selLo && portSel == `SPA_PORT_BAUD) begin
        rdData_r <= baudDivisor_r;
      end else if (selLo && portSel == `SPA_PORT_RX) begin
        rdData_r <= {7'h00, rxHold_r};
      end else if (selHi && portSel == `SPA_PORT_TX) begin
        rdData_r <= {7'h00, txShift_r};
      end else if (selHi && portSel == `SPA_PORT_RX) begin
        rdData_r <= {7'h00, rxShift_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  logic txStep, txLastBit, txWordEnd;
  assign txStep = asyncMode ? (tick && txCnt_r == `SPA_BIT_LAST) : syncRise;
  assign txLastBit = (txState_r == spa_pkg::TX_PARITY) ||
                     (txState_r == spa_pkg::TX_DATA && txIdx_r == lastIdx &&
                      !ctrl_r[`SPA_B_PEN]);
  assign txWordEnd = txStep && (asyncMode ? txState_r == spa_pkg::TX_STOP
                                          : txLastBit);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txState_r <= spa_pkg::TX_IDLE;
      txCnt_r <= 4'h0;
      txIdx_r <= 4'h0;
      txDoneIrq_r <= 1'b0;
    end else begin
      txDoneIrq_r <= 1'b0;
      if (tick) begin
        txCnt_r <= txCnt_r + 4'h1;
      end
      unique case (txState_r)
        spa_pkg::TX_IDLE: begin
          txIdx_r <= 4'h0;
          if (txShiftFull_r && asyncMode && tick) begin
            txState_r <= spa_pkg::TX_START;
            txCnt_r <= 4'h0;
          end else if (txShiftFull_r && syncMode && syncRise) begin
            txState_r <= spa_pkg::TX_DATA;
          end
        end
        spa_pkg::TX_START: begin
          if (txStep) begin
            txState_r <= spa_pkg::TX_DATA;
          end
        end
        spa_pkg::TX_DATA: begin
          if (txStep) begin
            txIdx_r <= txIdx_r + 4'h1;
            if (txIdx_r == lastIdx) begin
              if (ctrl_r[`SPA_B_PEN]) begin
                txState_r <= spa_pkg::TX_PARITY;
              end else begin
                txState_r <= asyncMode ? spa_pkg::TX_STOP : spa_pkg::TX_IDLE;
                txDoneIrq_r <= 1'b1;
              end
            end
          end
        end
        spa_pkg::TX_PARITY: begin
          if (txStep) begin
            txState_r <= asyncMode ? spa_pkg::TX_STOP : spa_pkg::TX_IDLE;
            txDoneIrq_r <= 1'b1;
          end
        end
        spa_pkg::TX_STOP: begin
          if (txStep) begin
            txState_r <= spa_pkg::TX_IDLE;
          end
        end
        default: begin
          txState_r <= spa_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // transmit double buffer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txShift_r <= 9'h000;
      txHold_r <= 9'h000;
      txShiftFull_r <= 1'b0;
      txHoldFull_r <= 1'b0;
    end else if (wrTxHold && !txShiftFull_r) begin
      txShift_r <= wrData[8:0];
      txShiftFull_r <= 1'b1;
    end else if (txWordEnd) begin
      if (txHoldFull_r) begin
        txShift_r <= txHold_r;
        txHoldFull_r <= 1'b0;
      end else if (wrTxHold) begin
        txShift_r <= wrData[8:0];
      end else begin
        txShiftFull_r <= 1'b0;
      end
    end else if (wrTxHold && !txHoldFull_r) begin
      txHold_r <= wrData[8:0];
      txHoldFull_r <= 1'b1;
    end
    // both full and no word ending: the write is dropped
  end

  logic txBit;
  always_comb begin
    unique case (txState_r)
      spa_pkg::TX_START: txBit = 1'b0;
      spa_pkg::TX_DATA: txBit = txShift_r[txIdx_r];
      spa_pkg::TX_PARITY: txBit = txParity;
      default: txBit = 1'b1;
    endcase
  end

  // pin drivers; codec mode leaves both pins idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txClkOut_r <= 1'b1;
      txClkOe_r <= 1'b1;
      rxDataOut_r <= 1'b1;
      rxDataOe_r <= 1'b0;
    end else begin
      txClkOut_r <= asyncMode ? txBit : (syncMode ? syncClk_r : 1'b1);
      txClkOe_r <= !(syncMode && !master);
      rxDataOut_r <= syncMode ? txBit : 1'b1;
      rxDataOe_r <= syncMode && (txState_r == spa_pkg::TX_DATA ||
                                 txState_r == spa_pkg::TX_PARITY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencer
  logic rxSample, rxMajority, rxHuntOk;
  assign rxSample = asyncMode ? (tick && rxCnt_r == `SPA_MID) : syncFall;
  assign rxMajority = (vote_r[0] & vote_r[1]) | (vote_r[0] & rxSync_r) |
                      (vote_r[1] & rxSync_r);
  assign rxHuntOk = !bbf_r && !rxDone_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxState_r <= spa_pkg::RX_HUNT;
      rxCnt_r <= 4'h0;
      rxIdx_r <= 4'h0;
      vote_r <= 2'h0;
      rxShift_r <= 9'h000;
      rxPerrPend_r <= 1'b0;
      rxDone_r <= 1'b0;
      ferrSet_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      ferrSet_r <= 1'b0;
      if (tick) begin
        rxCnt_r <= rxCnt_r + 4'h1;
      end
      unique case (rxState_r)
        spa_pkg::RX_HUNT: begin
          rxIdx_r <= 4'h0;
          if (rxHuntOk && asyncMode && rxPrev_r && !rxSync_r) begin
            rxState_r <= spa_pkg::RX_START;
            rxCnt_r <= 4'h0;
          end else if (rxHuntOk && syncRxEn && syncFall) begin
            rxShift_r <= {8'h00, rxSync_r};
            rxPerrPend_r <= 1'b0;
            rxIdx_r <= 4'h1;
            rxState_r <= spa_pkg::RX_DATA;
          end
        end
        spa_pkg::RX_START: begin
          if (tick && rxCnt_r == `SPA_VOTE_A) begin
            vote_r[0] <= rxSync_r;
          end
          if (tick && rxCnt_r == `SPA_VOTE_B) begin
            vote_r[1] <= rxSync_r;
          end
          if (tick && rxCnt_r == `SPA_VOTE_C) begin
            rxShift_r <= 9'h000;
            rxPerrPend_r <= 1'b0;
            rxState_r <= rxMajority ? spa_pkg::RX_HUNT
                                    : spa_pkg::RX_DATA;
          end
        end
        spa_pkg::RX_DATA: begin
          if (rxSample) begin
            rxShift_r[rxIdx_r] <= rxSync_r;
            rxIdx_r <= rxIdx_r + 4'h1;
            if (rxIdx_r == lastIdx) begin
              if (ctrl_r[`SPA_B_PEN]) begin
                rxState_r <= spa_pkg::RX_PARITY;
              end else if (asyncMode) begin
                rxState_r <= spa_pkg::RX_STOP;
              end else begin
                rxState_r <= spa_pkg::RX_HUNT;
                rxDone_r <= 1'b1;
              end
            end
          end
        end
        spa_pkg::RX_PARITY: begin
          if (rxSample) begin
            rxPerrPend_r <= (rxSync_r != rxParity);
            if (asyncMode) begin
              rxState_r <= spa_pkg::RX_STOP;
            end else begin
              rxState_r <= spa_pkg::RX_HUNT;
              rxDone_r <= 1'b1;
            end
          end
        end
        spa_pkg::RX_STOP: begin
          if (rxSample) begin
            ferrSet_r <= !rxSync_r;
            rxState_r <= spa_pkg::RX_HUNT;
            rxDone_r <= 1'b1;
          end
        end
        default: begin
          rxState_r <= spa_pkg::RX_HUNT;
        end
      endcase
    end
  end

  // receive holding and both-full handling
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxHold_r <= 9'h000;
      rxHoldFull_r <= 1'b0;
      bbf_r <= 1'b0;
      rxDoneIrq_r <= 1'b0;
    end else begin
      rxDoneIrq_r <= rxMove;
      if (rxMove) begin
        rxHold_r <= rxShift_r;
        rxHoldFull_r <= 1'b1;
        bbf_r <= 1'b0;
      end else if (rxDone_r) begin
        bbf_r <= 1'b1;
      end else if (rdRxHold) begin
        rxHoldFull_r <= 1'b0;
      end
    end
  end
endmodule

//--- bench/spa_chk_assertions.sv
// assertions on the serial port core ports
`timescale 1ns/1ps
module spa_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire logic [2:0] bank,
  input wire logic [2:0] portSel,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [15:0] wrData,
  input wire logic [15:0] rdData_r,
  // pins and events
  input wire logic txDoneIrq_r,
  input wire logic rxDoneIrq_r,
  input wire logic txClkOut_r,
  input wire logic txClkOe_r,
  input wire logic rxDataOut_r,
  input wire logic rxDataOe_r,
  input wire logic cpuClockOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] ctrl_r;
  logic [15:0] div_r;
  logic [1:0] age_r;
  logic seenHi_r;
  int lowCnt_r;
  logic ok;
  // registered outputs lag a mode change, so wait three cycles
  assign ok = age_r == 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 16'h0001;
      div_r <= 16'h0000;
    end else if (wrEn && bank == 3'h5 && portSel == 3'h0) begin
      ctrl_r <= wrData;
    end else if (wrEn && bank == 3'h5 && portSel == 3'h5) begin
      div_r <= wrData;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || ctrl_r[0] || ctrl_r[14]) begin
      age_r <= 2'h0;
    end else if (!ok) begin
      age_r <= age_r + 2'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || !ok) begin
      seenHi_r <= 1'b0;
      lowCnt_r <= 0;
    end else if (txClkOut_r) begin
      seenHi_r <= 1'b1;
      lowCnt_r <= 0;
    end else if (seenHi_r) begin
      lowCnt_r <= lowCnt_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_quarter;
    cpuClockOut ##1 !cpuClockOut [*2] ##1 cpuClockOut;
  endsequence
  sequence s_stop_high;
    ##2 txClkOut_r [*8];
  endsequence
  a_cpu_clk_div: assert property ($rose(cpuClockOut) |=> s_quarter)
    else $error("cpu clock output not a quarter of ref_clk");
  a_tx_bit_len: assert property (ok && seenHi_r && $rose(txClkOut_r)
    |-> lowCnt_r % (64 * (int'(div_r) + 1)) == 0)
    else $error("low run on transmit pin not whole bits");
  a_tx_irq_stop: assert property (ok && txDoneIrq_r |-> s_stop_high)
    else $error("no stop bit after transmit interrupt");
  a_tx_irq_pulse: assert property ($rose(txDoneIrq_r) |=>
    !txDoneIrq_r [*8])
    else $error("transmit interrupt longer than one pulse");
  a_rx_irq_pulse: assert property ($rose(rxDoneIrq_r) |=>
    !rxDoneIrq_r [*8])
    else $error("receive interrupt longer than one pulse");
  a_async_pins: assert property (ok |-> txClkOe_r && !rxDataOe_r
    && rxDataOut_r)
    else $error("pin directions wrong in async mode");
  a_tx_hold_wo: assert property (rdEn && bank == 3'h5
    && portSel == 3'h3 |=> rdData_r == 16'h0000)
    else $error("transmit holding register readable");
  a_rx_upper_zero: assert property (rdEn && portSel == 3'h4 |=>
    rdData_r[15:9] == 7'h00)
    else $error("receive word not right justified");
endmodule

bind spa_core spa_chk chk (.ref_clk(ref_clk), .rst(rst), .bank(bank),
  .portSel(portSel), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData),
  .rdData_r(rdData_r), .txDoneIrq_r(txDoneIrq_r),
  .rxDoneIrq_r(rxDoneIrq_r), .txClkOut_r(txClkOut_r),
  .txClkOe_r(txClkOe_r), .rxDataOut_r(rxDataOut_r),
  .rxDataOe_r(rxDataOe_r), .cpuClockOut(cpuClockOut));

//--- bench/spa_line_model.sv
// remote serial transceiver on the line
`timescale 1ns/1ps
module spa_line_model (
  // clock
  input wire logic ref_clk,
  // line from and to the core
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  task automatic put(input logic b, input int bl);
    @(posedge ref_clk) #1;
    lineOut = b;
    repeat (bl - 1) @(posedge ref_clk);
  endtask
  task automatic glitch(input int w);
    @(posedge ref_clk) #1;
    lineOut = 1'b0;
    repeat (w) @(posedge ref_clk);
    #1 lineOut = 1'b1;
  endtask
  // parity bit value is passed in so a frame can be sent corrupted
  task automatic send(input logic [8:0] d, input int n, input logic pen,
    input logic par, input logic stopBit, input int bl);
    put(1'b0, bl);
    for (int i = 0; i < n; i++) put(d[i], bl);
    if (pen) put(par, bl);
    put(stopBit, bl);
    if (!stopBit) put(1'b1, bl);
  endtask
  task automatic get(input int n, input logic pen, input int bl,
    output logic [8:0] d, output logic par, output logic stopBit);
    d = 9'h000;
    par = 1'b0;
    @(negedge lineIn);
    repeat (bl / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (bl) @(posedge ref_clk);
      d[i] = lineIn;
    end
    if (pen) begin
      repeat (bl) @(posedge ref_clk);
      par = lineIn;
    end
    repeat (bl) @(posedge ref_clk);
    stopBit = lineIn;
  endtask
endmodule

//--- bench/test_serial_port_async_core.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
module test_serial_port_async_core;
  logic ref_clk, rst, wrEn, rdEn, rxDataIn, txClkOut_r, txClkOe_r;
  logic txDoneIrq_r, rxDoneIrq_r, rxDataOut_r, rxDataOe_r, cpuClockOut;
  logic [2:0] bank, portSel;
  logic [15:0] wrData, rdData_r;
  logic [31:0] seed;
  int errors, num_checks, cycles, rxIrqs, txIrqs;
  ////////////////////////////////////////////////////////////////////////////
  spa_core uut (.ref_clk(ref_clk), .rst(rst), .bank(bank),
    .portSel(portSel), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData),
    .rdData_r(rdData_r), .txDoneIrq_r(txDoneIrq_r),
    .rxDoneIrq_r(rxDoneIrq_r), .txClkIn(1'b1), .txClkOut_r(txClkOut_r),
    .txClkOe_r(txClkOe_r), .rxDataIn(rxDataIn), .rxDataOut_r(rxDataOut_r),
    .rxDataOe_r(rxDataOe_r), .cpuClockOut(cpuClockOut));
  spa_line_model far (.ref_clk(ref_clk), .lineIn(txClkOut_r),
    .lineOut(rxDataIn));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (rxDoneIrq_r === 1'b1) rxIrqs++;
    if (txDoneIrq_r === 1'b1) txIrqs++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [8:0] msk(logic [8:0] d, int n);
    return d & 9'((1 << n) - 1);
  endfunction
  function automatic logic pbit(logic [8:0] d, int n, logic odd);
    return (^msk(d, n)) ^ odd;
  endfunction
  function automatic logic [15:0] cfg(int c, logic pen, logic odd);
    return 16'h0800 | 16'(c << 1) | {6'h00, odd, pen, 8'h00};
  endfunction
  task automatic wr(input logic [2:0] b, input logic [2:0] p,
    input logic [15:0] d);
    @(posedge ref_clk) #1;
    bank = b;
    portSel = p;
    wrData = d;
    wrEn = 1'b1;
    @(posedge ref_clk) #1;
    wrEn = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [2:0] b,
    input logic [2:0] p, input logic [15:0] e);
    @(posedge ref_clk) #1;
    bank = b;
    portSel = p;
    rdEn = 1'b1;
    @(posedge ref_clk) #1;
    rdEn = 1'b0;
    @(posedge ref_clk) #1;
    chk(nm, e, rdData_r);
  endtask
  task automatic wait_irq(input int want);
    int t;
    t = 0;
    while (rxIrqs < want && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
    chk("rx interrupts", 16'(want), 16'(rxIrqs));
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [8:0] d0, d1, g;
    logic gp, gs, pen, odd;
    int n, k, base;
    seed = 32'h5669FDA6;
    {rst, wrEn, rdEn, bank, portSel, wrData} = {3'h4, 6'h00, 16'h0000};
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    rchk("control reset", 3'h5, 3'h0, 16'h8805);
    wr(3'h5, 3'h5, 16'hFFFF);
    rchk("divisor max", 3'h5, 3'h5, 16'hFFFF);
    rst = 1'b1;
    @(posedge ref_clk) #1 rst = 1'b0;
    wr(3'h5, 3'h5, 16'h0000);
    rchk("unmapped", 3'h5, 3'h7, 16'h0000);
    rchk("tx hold wo", 3'h5, 3'h3, 16'h0000);
    // back-to-back writes, third one lands while both are full
    for (int c = 0; c < 4; c++) begin
      n = 6 + c;
      pen = 1'(xs());
      odd = 1'(xs());
      v = cfg(c, pen, odd);
      wr(3'h5, 3'h0, v);
      d0 = 9'(xs());
      d1 = 9'(xs());
      base = txIrqs;
      fork
        begin
          far.get(n, pen, 64, g, gp, gs);
          chk("tx data", 16'(msk(d0, n)), 16'(g));
          chk("tx parity", 16'(pen & pbit(d0, n, odd)), 16'(gp));
          far.get(n, pen, 64, g, gp, gs);
          chk("tx data queued", 16'(msk(d1, n)), 16'(g));
          chk("tx stop", 16'h0001, 16'(gs));
        end
        begin
          wr(3'h5, 3'h3, 16'(d0));
          wr(3'h5, 3'h3, 16'(d1));
          rchk("tx buffer full", 3'h5, 3'h0, v);
          wr(3'h5, 3'h3, 16'(~d1));
        end
      join
      repeat (700) @(posedge ref_clk);
      #1 chk("tx frames", 16'(base + 2), 16'(txIrqs));
      chk("tx idle", 16'h0001, 16'(txClkOut_r));
      rchk("tx buffer empty", 3'h5, 3'h0, v | 16'h8000);
      rchk("tx shift", 3'h7, 3'h3, 16'(d1));
    end
    // receive: lengths, glitch, parity fault, missing stop, slower rate
    for (int c = 0; c < 4; c++) begin
      n = 6 + c;
      pen = (c == 2) ? 1'b1 : 1'(xs());
      odd = 1'(xs());
      k = c % 2;
      v = cfg(c, pen, odd);
      wr(3'h5, 3'h0, v);
      wr(3'h5, 3'h5, 16'(k));
      d0 = 9'(xs());
      if (c == 1) far.glitch(12);
      repeat (128) @(posedge ref_clk);
      far.send(d0, n, pen, pbit(d0, n, odd) ^ (c == 2), c != 3, 64 * (k + 1));
      wait_irq(c + 1);
      rchk("rx data", 3'h5, 3'h4, 16'(msk(d0, n)));
      rchk("rx status", 3'h5, 3'h0, v | 16'h8000 | (c == 2 ? 16'h0008 : 16'h0)
        | (c == 3 ? 16'h0010 : 16'h0));
    end
    // second word arrives while holding is occupied and carries bad parity
    v = cfg(2, 1'b1, 1'b0);
    wr(3'h5, 3'h0, v);
    wr(3'h5, 3'h5, 16'h0000);
    d0 = 9'(xs());
    d1 = 9'(xs());
    far.send(d0, 8, 1'b1, pbit(d0, 8, 1'b0), 1'b1, 64);
    far.send(d1, 8, 1'b1, ~pbit(d1, 8, 1'b0), 1'b1, 64);
    repeat (8) @(posedge ref_clk);
    chk("rx interrupts full", 16'h0005, 16'(rxIrqs));
    rchk("both full", 3'h5, 3'h0, v | 16'h8020);
    rchk("rx first", 3'h5, 3'h4, 16'(msk(d0, 8)));
    wait_irq(6);
    rchk("parity carried", 3'h5, 3'h0, v | 16'h8008);
    rchk("rx second", 3'h5, 3'h4, 16'(msk(d1, 8)));
    end_of_test();
  end
endmodule
